// ==== rtl/fault_log_pkg.sv ====
// Constants and types shared by the fault log page scanner
// Summary of operation
// R01: Scan flash pages after every reset
// R02: Judge page only by flag byte 0x00
// R03: Occupied page: advance counter, check next page
// R04: Write new fault into first empty page
// R05: Controller erases flash, pulses clear low
// R06: Clear request returns page counter to zero
// R07: Show stored record count after scan
// R08: Blink indicator while any record stored
// R09: Each written record bumps count by one
// R10: Two-bit channel status codes, 10 invalid
// R11: Controller port four SPI plus four arbitration
// R12: Flag 0xFF empty, 0xC3 written
// R13: Memory full at 250 records, no writes
// R14: No flash access while ready low, one pending; ready is only checked before the first scan read and before a write
// R15: Scan hitting limit sets full, count limit
package fault_log_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 25;
  localparam int SPI_HALF_NS    = 100;
  localparam int SPI_HALF_CYC   = (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_GAP_NS      = 100;
  localparam int CS_GAP_CYC     = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLINK_HALF_MS  = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * (1000000 / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Flash page layout and commands
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAG_EMPTY = 8'hFF;
  localparam logic [7:0] FLAG_USED  = 8'hC3;
  localparam logic [7:0] FLAG_BYTE  = 8'h00;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  localparam logic [7:0] CMD_READ   = 8'h03;
  localparam logic [7:0] CMD_WREN   = 8'h06;
  localparam logic [7:0] CMD_PROG   = 8'h02;
  localparam logic [7:0] CMD_RDSR   = 8'h05;
  localparam int         WIP_BIT    = 0;
  localparam int         FAULT_LIMIT = 250;
  localparam int         REC_BYTES  = 9;
  localparam logic [3:0] LEN_READ   = 4'h5;
  localparam logic [3:0] LEN_WREN   = 4'h1;
  localparam logic [3:0] LEN_POLL   = 4'h2;
  localparam logic [3:0] LEN_PROG   = 4'hE;
  localparam logic [3:0] IDX_ADDR_HI = 4'h1;
  localparam logic [3:0] IDX_ADDR_PG = 4'h2;
  localparam logic [3:0] IDX_ADDR_LO = 4'h3;
  localparam logic [3:0] IDX_FLAG   = 4'h4;
  localparam int         NUM_CHAN   = 12;

  // Channel status codes
  localparam logic [1:0] VM_UNDER   = 2'h0; // R10
  localparam logic [1:0] VM_GOOD    = 2'h3; // R10
  localparam logic [1:0] VM_OVER    = 2'h1; // R10
  localparam logic [1:0] VM_INVALID = 2'h2; // R10

  // ----------------------------------------------------------------
  // Register map and event bits
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_ENABLE = 4'h4;
  localparam logic [3:0] REG_CLEAR  = 4'h8;
  localparam logic [3:0] REG_INFO   = 4'hC;
  localparam int EV_SCAN    = 0;
  localparam int EV_WRITTEN = 1;
  localparam int EV_DROP    = 2;
  localparam int EV_CLEAR   = 3;
  localparam int EV_INVALID = 4;
  localparam int NUM_EV     = 5;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_IDLE = 2'b01,
    ST_XFER = 2'b10,
    ST_GAP  = 2'b11
  } main_state_type;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WREN = 2'b01,
    OP_PROG = 2'b10,
    OP_POLL = 2'b11
  } op_type;

endpackage : fault_log_pkg

// ==== rtl/sync_two_stage.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync_two_stage #(
  parameter int        WIDTH = 1,
  parameter logic [0:0] INIT = 1'b0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q   <= {WIDTH{INIT}};
      sync_out <= {WIDTH{INIT}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : sync_two_stage

// ==== rtl/spi_byte_engine.sv ====
// SPI mode 0 byte shifter with its own clock divider
`timescale 1ns/1ps
module spi_byte_engine
  import fault_log_pkg::*;
#(
  parameter int HALF_CYC = SPI_HALF_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Byte request
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  output logic            done,
  output logic [7:0]      rx_byte,
  // Serial lines
  output logic            sclk,
  output logic            mosi,
  input  wire logic       miso_s
);

  logic [7:0] div_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic       busy_q;
  logic       tick;

  // Half-period enable while shifting
  assign tick = busy_q && (div_q == 8'(HALF_CYC - 1));

  always_ff @(posedge clk) begin
    if (!rst_n || !busy_q || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Rising edge only raises the clock; falling edge samples, shifts and drives the next bit out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q  <= 1'b0;
      sclk    <= 1'b0;
      mosi    <= 1'b0;
      sh_q    <= 8'h00;
      bit_q   <= 3'h0;
      done    <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy_q && !done) begin // Done cycle lets the caller step its byte index
        busy_q <= 1'b1;
        sh_q   <= tx_byte;
        mosi   <= tx_byte[7];
        bit_q  <= 3'h0;
      end else if (tick && !sclk) begin
        sclk <= 1'b1;
      end else if (tick) begin
        sclk <= 1'b0;
        sh_q <= {sh_q[6:0], miso_s};
        mosi <= sh_q[6];
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          busy_q  <= 1'b0;
          done    <= 1'b1;
          rx_byte <= {sh_q[6:0], miso_s};
        end
      end
    end
  end

endmodule : spi_byte_engine

// ==== rtl/fault_log_scanner.sv ====
// Fault log page scanner, writer, arbitration and register port
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module fault_log_scanner
  import fault_log_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_HALF_CYC,
  parameter int LIMIT     = FAULT_LIMIT
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Captured fault record
  input  wire logic        fault_valid,
  input  wire logic [71:0] fault_record,
  // Controller SPI port
  input  wire logic        mcu_sclk,
  input  wire logic        mcu_cs_n,
  input  wire logic        mcu_mosi,
  output logic             mcu_miso,
  // Controller arbitration
  input  wire logic        ready,
  input  wire logic        mem_clear_n,
  output logic             busy,
  output logic             mem_full,
  // Flash SPI port
  output logic             flash_sclk,
  output logic             flash_cs_n,
  output logic             flash_mosi,
  input  wire logic        flash_miso,
  // Display and indicator
  output logic [7:0]       fault_count,
  output logic             fault_led,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] mcu_s;
  logic       ready_s;
  logic       clear_s;
  logic       miso_s;
  logic       clear_d1_q;
  logic       clear_evt;

  sync_two_stage #(.WIDTH(3), .INIT(1'b1)) u_sync_mcu (
    .clk(clk), .rst_n(rst_n),
    .async_in({mcu_sclk, mcu_cs_n, mcu_mosi}), .sync_out(mcu_s));
  sync_two_stage #(.WIDTH(3), .INIT(1'b1)) u_sync_arb (
    .clk(clk), .rst_n(rst_n),
    .async_in({ready, mem_clear_n, flash_miso}), .sync_out({ready_s, clear_s, miso_s}));

  // Falling edge of the clear request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clear_d1_q <= 1'b1;
    end else begin
      clear_d1_q <= clear_s;
    end
  end
  assign clear_evt = clear_d1_q && !clear_s;

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  main_state_type state_q;
  op_type         op_q;
  logic [3:0]     idx_q;
  logic [3:0]     len_q;
  logic [7:0]     page_q;
  logic [71:0]    rec_q;
  logic           pend_q;
  logic           scanned_q;
  logic           full_q;
  logic           eng_start;
  logic           eng_done;
  logic [7:0]     eng_rx;
  logic           eng_sclk;
  logic           eng_mosi;
  logic [7:0]     tx_byte;
  logic [2:0]     gap_q;
  logic           gap_end;
  logic           owned;

  // Byte sent at position idx of the current operation
  function automatic logic [7:0] byte_at(op_type op, logic [3:0] idx,
                                         logic [7:0] page, logic [71:0] rec);
    logic [7:0] b;
    b = ZERO_BYTE;
    if (idx == 4'h0) begin
      unique case (op)
        OP_READ: b = CMD_READ;
        OP_WREN: b = CMD_WREN;
        OP_PROG: b = CMD_PROG;
        OP_POLL: b = CMD_RDSR;
      endcase
    end else if (idx == IDX_ADDR_PG && (op == OP_READ || op == OP_PROG)) begin
      b = page;
    end else if (idx == IDX_FLAG && op == OP_PROG) begin
      b = FLAG_USED; // R12
    end else if (idx > IDX_FLAG && op == OP_PROG) begin
      b = rec[8 * (32'(idx) - 32'(IDX_FLAG) - 1) +: 8]; // R04
    end
    return b;
  endfunction : byte_at

  assign tx_byte   = byte_at(op_q, idx_q, page_q, rec_q);
  assign owned     = ready_s; // R14
  assign eng_start = (state_q == ST_XFER) && !flash_cs_n;

  spi_byte_engine #(.HALF_CYC(SPI_HALF_CYC)) u_engine (
    .clk(clk), .rst_n(rst_n), .start(eng_start), .tx_byte(tx_byte),
    .done(eng_done), .rx_byte(eng_rx), .sclk(eng_sclk), .mosi(eng_mosi),
    .miso_s(miso_s));

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic last_byte;
  logic scan_eval;
  logic write_done;
  logic at_limit;

  assign last_byte  = eng_done && (idx_q == len_q - 4'h1);
  assign gap_end    = (state_q == ST_GAP) && (gap_q == 3'(CS_GAP_CYC - 1));
  assign at_limit   = (page_q == 8'(LIMIT - 1));
  assign scan_eval  = gap_end && (op_q == OP_READ);
  assign write_done = gap_end && (op_q == OP_POLL) && !eng_rx[WIP_BIT];

  // Gap timer keeps chip select high between commands
  always_ff @(posedge clk) begin
    if (!rst_n || state_q != ST_GAP) begin
      gap_q <= 3'h0;
    end else begin
      gap_q <= gap_q + 3'h1;
    end
  end

  // Main sequence of flash operations
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q    <= ST_BOOT;
      op_q       <= OP_READ;
      idx_q      <= 4'h0;
      len_q      <= LEN_READ;
      flash_cs_n <= 1'b1;
      scanned_q  <= 1'b0;
    end else begin
      unique case (state_q)
        ST_BOOT: begin
          if (owned) begin // R01
            state_q    <= ST_XFER;
            op_q       <= OP_READ;
            len_q      <= LEN_READ;
            idx_q      <= 4'h0;
            flash_cs_n <= 1'b0;
          end
        end
        ST_IDLE: begin
          if (pend_q && owned && !full_q) begin // R13
            state_q    <= ST_XFER;
            op_q       <= OP_WREN;
            len_q      <= LEN_WREN;
            idx_q      <= 4'h0;
            flash_cs_n <= 1'b0;
          end
        end
        ST_XFER: begin
          if (last_byte) begin
            state_q    <= ST_GAP;
            flash_cs_n <= 1'b1;
          end else if (eng_done) begin
            idx_q <= idx_q + 4'h1;
          end
        end
        ST_GAP: begin
          if (gap_end) begin
            idx_q <= 4'h0;
            unique case (op_q)
              OP_READ: begin
                if (eng_rx != FLAG_EMPTY && !at_limit) begin // R02 R03
                  state_q    <= ST_XFER;
                  flash_cs_n <= 1'b0;
                end else begin
                  state_q   <= ST_IDLE;
                  scanned_q <= 1'b1;
                end
              end
              OP_WREN: begin
                op_q       <= OP_PROG;
                len_q      <= LEN_PROG;
                state_q    <= ST_XFER;
                flash_cs_n <= 1'b0;
              end
              OP_PROG, OP_POLL: begin
                if (op_q == OP_POLL && !eng_rx[WIP_BIT]) begin
                  state_q <= ST_IDLE;
                end else begin
                  op_q       <= OP_POLL;
                  len_q      <= LEN_POLL;
                  state_q    <= ST_XFER;
                  flash_cs_n <= 1'b0;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  // Page counter: clear request wins over advance
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      page_q <= 8'h00;
      full_q <= 1'b0;
    end else if (clear_evt) begin
      page_q <= 8'h00; // R06
      full_q <= 1'b0;
    end else if (scan_eval && eng_rx != FLAG_EMPTY) begin
      if (at_limit) begin
        page_q <= 8'(LIMIT); // R15
        full_q <= 1'b1;
      end else begin
        page_q <= page_q + 8'h01; // R03
      end
    end else if (write_done) begin
      page_q <= page_q + 8'h01; // R09
      full_q <= at_limit; // R13
    end
  end

  // One pending record; later arrivals are dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      rec_q  <= 72'h0;
    end else if (fault_valid && !pend_q) begin
      pend_q <= 1'b1; // R14
      rec_q  <= fault_record;
    end else if (write_done || (pend_q && full_q && state_q == ST_IDLE)) begin
      pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin multiplexer and status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flash_sclk  <= 1'b0;
      flash_mosi  <= 1'b0;
      mcu_miso    <= 1'b0;
      busy        <= 1'b0;
      mem_full    <= 1'b0;
      fault_count <= 8'h00;
    end else begin
      flash_sclk  <= owned ? eng_sclk : mcu_s[2]; // R11
      flash_mosi  <= owned ? eng_mosi : mcu_s[0];
      mcu_miso    <= mcu_s[1] ? 1'b0 : miso_s; // R11
      busy        <= pend_q || state_q == ST_XFER || state_q == ST_GAP;
      mem_full    <= full_q;
      fault_count <= scanned_q ? page_q : 8'h00; // R07
    end
  end

  // ----------------------------------------------------------------
  // Blinking indicator
  // ----------------------------------------------------------------
  logic [31:0] blink_q;
  always_ff @(posedge clk) begin
    if (!rst_n || fault_count == 8'h00) begin
      blink_q   <= 32'h0;
      fault_led <= 1'b0; // R08
    end else if (blink_q == 32'(BLINK_CYC - 1)) begin
      blink_q   <= 32'h0;
      fault_led <= !fault_led; // R08
    end else begin
      blink_q <= blink_q + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Events, registers and interrupt
  // ----------------------------------------------------------------
  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] status_q;
  logic [NUM_EV-1:0] enable_q;
  logic              bad_chan;

  // Any channel reporting the invalid code
  always_comb begin
    bad_chan = 1'b0;
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (fault_record[2*c +: 2] == VM_INVALID) begin
        bad_chan = 1'b1; // R10
      end
    end
  end

  assign ev[EV_SCAN]    = scan_eval && (eng_rx == FLAG_EMPTY || at_limit);
  assign ev[EV_WRITTEN] = write_done;
  assign ev[EV_DROP]    = fault_valid && pend_q;
  assign ev[EV_CLEAR]   = clear_evt;
  assign ev[EV_INVALID] = fault_valid && bad_chan;

  // Sticky status: a new event wins over a clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= '0;
    end else if (reg_wr && reg_addr == REG_CLEAR) begin
      status_q <= (status_q & ~reg_wdata[NUM_EV-1:0]) | ev;
    end else begin
      status_q <= status_q | ev;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_q <= '0;
    end else if (reg_wr && reg_addr == REG_ENABLE) begin
      enable_q <= reg_wdata[NUM_EV-1:0];
    end
  end

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk) begin
    if (!rst_n || !reg_rd) begin
      reg_rdata <= 32'h0;
    end else begin
      unique case (reg_addr)
        REG_STATUS: reg_rdata <= 32'(status_q);
        REG_ENABLE: reg_rdata <= 32'(enable_q);
        REG_INFO:   reg_rdata <= {20'h0, scanned_q, full_q, pend_q, ready_s, page_q};
        default:    reg_rdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & enable_q);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_scan_first: assert property ((op_q == OP_WREN) |-> scanned_q) // R01
    else $error("write started before start-up scan");
  a_flag_addr: assert property ((op_q == OP_READ && idx_q == IDX_ADDR_LO) |-> tx_byte == FLAG_BYTE) // R02
    else $error("scan does not read flag byte");
  a_scan_step: assert property ((scan_eval && eng_rx != FLAG_EMPTY && !at_limit && !clear_evt)
    |=> page_q == $past(page_q) + 8'h01) // R03
    else $error("scan did not advance page");
  a_prog_page: assert property ((op_q == OP_PROG && idx_q == IDX_ADDR_PG) |-> tx_byte == page_q) // R04
    else $error("program aimed at wrong page");
  a_clear_page: assert property (clear_evt |=> page_q == 8'h00 && !full_q) // R06
    else $error("clear did not reset page");
  a_count_show: assert property (scanned_q |=> fault_count == $past(page_q)) // R07
    else $error("display count wrong");
  a_led_idle: assert property ((fault_count == 8'h00) |=> !fault_led) // R08
    else $error("indicator active with no records");
  a_write_inc: assert property ((write_done && !clear_evt) |=> page_q == $past(page_q) + 8'h01) // R09
    else $error("count not bumped after write");
  a_flag_used: assert property ((op_q == OP_PROG && idx_q == IDX_FLAG) |-> tx_byte == FLAG_USED) // R12
    else $error("wrong flag byte written");
  a_full_stop: assert property ((full_q && state_q == ST_IDLE) |=> state_q == ST_IDLE) // R13
    else $error("write begun while full");
  a_ready_hold: assert property ((!owned && state_q == ST_IDLE) |=> state_q == ST_IDLE) // R14
    else $error("flash accessed while ready low");
  a_scan_limit: assert property ((scan_eval && at_limit && eng_rx != FLAG_EMPTY && !clear_evt)
    |=> full_q && page_q == 8'(LIMIT)) // R15
    else $error("limit not reported");

endmodule : fault_log_scanner

// ==== test/flash_model.sv ====
// Behavioural serial flash keeping sixteen bytes of each page
`timescale 1ns/1ps
module flash_model (
  // Serial lines
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  output logic      miso,
  // Status shows busy for three polls after a program
  input  wire logic slow
);
  // ----------------------------------------
  // Page store and shifters
  // ----------------------------------------
  logic [7:0] mem [256][16];
  logic [7:0] cmd, page, lo, sin, sout;
  int         nbit, nbyte, busy_left;

  // Power-up state
  initial begin
    miso = 1'b0;
    cmd = 8'h00;
    busy_left = 0;
  end

  // New frame restarts the bit count
  always @(negedge cs_n) begin
    nbit = 0;
    sout = 8'h00;
  end

  // Released line inverts the last bit; a program starts the busy time
  always @(posedge cs_n) begin
    miso = ~miso;
    if (cmd == 8'h02 && slow) busy_left = 3;
  end

  // Shift in on rising edge, act on each whole byte
  always @(posedge sclk) begin
    if (!cs_n) begin
      sin = {sin[6:0], mosi};
      nbit++;
      nbyte = nbit / 8;
      if (nbit % 8 == 0) begin
        if (nbyte == 1) cmd = sin;
        if (nbyte == 3) page = sin;
        if (nbyte == 4) lo = sin;
        if (nbyte >= 5 && cmd == 8'h02) begin
          mem[page][lo[3:0]] = sin;
          lo++;
        end
        if (nbyte >= 4 && cmd == 8'h03) begin
          sout = mem[page][lo[3:0]];
          lo++;
        end
        if (nbyte == 1 && cmd == 8'h05) begin
          sout = {7'h00, busy_left != 0};
          if (busy_left > 0) busy_left--;
        end
      end
    end
  end

  // Shift out on falling edge, most significant bit first
  always @(negedge sclk) begin
    if (!cs_n) begin
      miso = sout[7];
      sout = {sout[6:0], 1'b0};
    end
  end
endmodule : flash_model

// ==== test/test_fault_log_scanner.sv ====
// Self-checking bench for the fault log page scanner
`timescale 1ns/1ps
module test_fault_log_scanner;
  import fault_log_pkg::*;
  localparam int LIM = 5;
  localparam logic [71:0] REC = 72'h090807060504FFFFDC;
  logic        clk, rst_n, fault_valid, ready, mem_clear_n, slow, reg_wr, reg_rd;
  logic        mcu_sclk, mcu_cs_n, mcu_mosi, mcu_miso, busy, mem_full, irq;
  logic        flash_sclk, flash_cs_n, flash_mosi, flash_miso, fault_led;
  logic [71:0] fault_record;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [7:0]  fault_count, c0;
  int          fails = 0, samples_checked = 0;

  // ----------------------------------------
  // Design, flash and clock
  // ----------------------------------------
  fault_log_scanner #(.BLINK_CYC(8), .LIMIT(LIM)) DUT (
    .clk(clk), .rst_n(rst_n), .fault_valid(fault_valid), .fault_record(fault_record),
    .mcu_sclk(mcu_sclk), .mcu_cs_n(mcu_cs_n), .mcu_mosi(mcu_mosi), .mcu_miso(mcu_miso),
    .ready(ready), .mem_clear_n(mem_clear_n), .busy(busy), .mem_full(mem_full),
    .flash_sclk(flash_sclk), .flash_cs_n(flash_cs_n), .flash_mosi(flash_mosi),
    .flash_miso(flash_miso), .fault_count(fault_count), .fault_led(fault_led),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  flash_model flash (.sclk(flash_sclk), .cs_n(flash_cs_n), .mosi(flash_mosi),
    .miso(flash_miso), .slow(slow));
  always #12.5 clk = ~clk;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : reg_read

  task automatic fault(input logic [71:0] r);
    @(posedge clk);
    fault_valid <= 1'b1;
    fault_record <= r;
    @(posedge clk);
    fault_valid <= 1'b0;
  endtask : fault

  // Bounded wait for the pending record to land
  task automatic wait_idle;
    repeat (4) @(posedge clk);
    #1;
    for (int i = 0; i < 8000 && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk("idle", 8'h0, 8'(busy));
    repeat (2) @(posedge clk);
    #1;
  endtask : wait_idle

  // Reports whether a signal changed within n cycles
  task automatic stays(ref logic s, input int n, input logic exp, input string what);
    logic l, moved;
    l = s;
    moved = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (s !== l) moved = 1'b1;
    end
    chk(what, 8'(exp), 8'(moved));
  endtask : stays

  // Preload flags, reset, wait for the scan to finish
  task automatic boot(input int used);
    for (int p = 0; p < 256; p++) flash.mem[p][0] = (p < used) ? 8'hC3 : 8'hFF;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd = '0;
    for (int i = 0; i < 3000 && rd[11] !== 1'b1; i++) reg_read(REG_INFO);
    chk("scan done", 8'h1, 8'(rd[11]));
    repeat (2) @(posedge clk);
    #1;
  endtask : boot

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_scan;
    boot(0);
    chk("blank count", 8'h0, fault_count);
    stays(fault_led, 40, 1'b0, "still led");
    boot(2);
    chk("scan count", 8'h2, fault_count);
    reg_read(REG_INFO);
    chk("scan page", 8'h2, rd[7:0]);
    stays(fault_led, 40, 1'b1, "blink");
  endtask : t_scan

  task automatic t_write;
    slow = 1'b1;
    fault(REC);
    wait_idle;
    chk("flag", 8'hC3, flash.mem[2][0]);
    for (int n = 1; n < 10; n++) chk("byte", REC[8*n-1 -: 8], flash.mem[2][n]);
    chk("old page", 8'hC3, flash.mem[1][0]);
    chk("count", 8'h3, fault_count);
    reg_read(REG_STATUS);
    chk("no invalid", 8'h0, 8'(rd[EV_INVALID]));
    reg_write(REG_ENABLE, 32'h10);
    fault(REC ^ 72'h2);
    wait_idle;
    chk("irq", 8'h1, 8'(irq));
    chk("count", 8'h4, fault_count);
    reg_write(REG_ENABLE, 32'h0);
    chk("masked", 8'h0, 8'(irq));
    reg_write(REG_ENABLE, 32'h10);
    reg_write(REG_CLEAR, 32'h10);
    chk("cleared", 8'h0, 8'(irq));
    reg_read(4'h2);
    chk("unmapped", 8'h0, rd[7:0]);
  endtask : t_write

  task automatic t_clear;
    @(posedge clk);
    ready <= 1'b0;
    for (int p = 0; p < 256; p++) flash.mem[p][0] = 8'hFF;
    mem_clear_n <= 1'b0;
    repeat (4) @(posedge clk);
    mem_clear_n <= 1'b1;
    ready <= 1'b1;
    repeat (6) @(posedge clk);
    reg_read(REG_INFO);
    chk("page", 8'h0, rd[7:0]);
    fault(REC);
    wait_idle;
    chk("restart", 8'hC3, flash.mem[0][0]);
  endtask : t_clear

  task automatic t_ready;
    c0 = fault_count;
    @(posedge clk);
    ready <= 1'b0;
    mcu_cs_n <= 1'b0;
    mcu_sclk <= 1'b1;
    mcu_mosi <= 1'b1;
    repeat (6) @(posedge clk);
    fault(REC);
    fault(REC);
    stays(flash_cs_n, 200, 1'b0, "cs held");
    chk("busy", 8'h1, 8'(busy));
    chk("pass sclk", 8'h1, 8'(flash_sclk));
    chk("pass mosi", 8'h1, 8'(flash_mosi));
    chk("pass miso", 8'(flash_miso), 8'(mcu_miso));
    @(posedge clk);
    ready <= 1'b1;
    mcu_sclk <= 1'b0;
    mcu_cs_n <= 1'b1;
    mcu_mosi <= 1'b0;
    wait_idle;
    chk("one more", c0 + 8'h1, fault_count);
    chk("written", 8'hC3, flash.mem[1][0]);
    chk("dropped", 8'hFF, flash.mem[2][0]);
    reg_read(REG_STATUS);
    chk("drop event", 8'h1, 8'(rd[EV_DROP]));
  endtask : t_ready

  task automatic t_limit;
    boot(LIM - 1);
    fault(REC);
    wait_idle;
    chk("full", 8'h1, 8'(mem_full));
    chk("last", 8'hC3, flash.mem[LIM-1][0]);
    fault(REC);
    stays(flash_cs_n, 300, 1'b0, "cs full");
    boot(LIM);
    chk("scan full", 8'h1, 8'(mem_full));
    chk("scan limit", 8'(LIM), fault_count);
  endtask : t_limit

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    {clk, rst_n, fault_valid, slow, reg_wr, reg_rd, mcu_sclk, mcu_mosi} = '0;
    {ready, mem_clear_n, mcu_cs_n} = '1;
    {fault_record, reg_addr, reg_wdata} = '0;
    t_scan;
    t_write;
    t_clear;
    t_ready;
    t_limit;
    complete_run;
  end

  // Watchdog
  initial begin
    #2000000;
    fails++;
    complete_run;
  end
endmodule : test_fault_log_scanner
